// ==== cdw_top.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Each fitted base jumper needs its address bit low; removed needs it high.
// - Two 32-byte windows, lower at 0x200..0x3E0 by jumpers, upper 0x400 above.
// - Base jumper state is readable in the board test and address select register.
// - Outputs update on write, or on timer expiry when the update jumper selects latching.
// - Every periodic timer expiry latches all encoder counters.
// - Periodic timer spans ten minutes in 25 us steps and can interrupt.
// - With watchdog enabled, any analog output write restarts the timeout.
// - Watchdog expiry forces every analog output to zero.
// - Route jumper fitted: fault line high after expiry until next board write.
// - Route jumper removed: expiry zeroes outputs and sets status bits, port bit stays free.
// - Watchdog disabled: internal oscillator keeps restarting it, it never expires.
// - Timeout lies between 62.5 ms and 250 ms, typically 150 ms.
module cdw_top #(
    parameter int unsigned TICK_CYCLES = cdw_pkg::TICK_CYCLES,
    parameter int unsigned WD_TICKS = cdw_pkg::WD_TICKS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic card_sel_o,
    input wire logic [3:0] base_address_jumpers_i,
    input wire logic output_update_select_jumper_i,
    input wire logic fault_output_route_jumper_i,
    input wire logic watchdog_enable_jumper_i,
    output logic [cdw_pkg::DAC_N-1:0][cdw_pkg::DAC_W-1:0] dac_o,
    output logic encoder_latch_o,
    output logic irq_o,
    output logic fault_o,
    output logic upper_port_bit_seven_o,
    output logic upper_port_bit_seven_oe_o
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [cdw_pkg::JMP_W-1:0] jmp_meta_q;
    logic [cdw_pkg::JMP_W-1:0] jmp_q;
    logic [3:0] jmp_base;
    logic upd_latched;
    logic route_fitted;
    logic wd_en;
    logic [15:0] base_lo;
    logic [15:0] base_hi;
    logic sel_lo;
    logic sel_hi;
    logic [4:0] ofs;
    logic host_wr;
    logic [cdw_pkg::DAC_N-1:0] dac_wr_ch;
    logic dac_wr_any;
    logic [cdw_pkg::PRE_W-1:0] pre_cnt_q, pre_cnt_d;
    logic tick;
    logic [cdw_pkg::TMR_W-1:0] reload_q, reload_d;
    logic [cdw_pkg::TMR_W-1:0] tcnt_q, tcnt_d;
    logic run_q, run_d;
    logic tmr_evt;
    logic tmr_evt_q;
    cdw_pkg::cdw_wd_state_t st_q, st_d;
    logic [cdw_pkg::WD_W-1:0] wd_cnt_q, wd_cnt_d;
    logic fault_q, fault_d;
    logic wd_expire;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [15:0] rdata_q, rdata_d;
    logic [cdw_pkg::DAC_W-1:0] pend_q [cdw_pkg::DAC_N];
    logic [cdw_pkg::DAC_W-1:0] act_q [cdw_pkg::DAC_N];

    // Reset is released through two flops so that every flop leaves reset on the same edge.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Jumpers are board straps from outside the clock domain.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            jmp_meta_q <= 7'h00;
            jmp_q <= 7'h00;
        end else begin
            jmp_meta_q <= {watchdog_enable_jumper_i, fault_output_route_jumper_i,
                           output_update_select_jumper_i, base_address_jumpers_i};
            jmp_q <= jmp_meta_q;
        end
    end
    assign jmp_base = jmp_q[3:0];
    assign upd_latched = jmp_q[4];
    assign route_fitted = jmp_q[5];
    assign wd_en = jmp_q[6];

    // A fitted jumper reads as one and demands a zero on its address bit.
    assign base_lo = cdw_pkg::IO_BASE | {7'h00, ~jmp_base, 5'h00};
    assign base_hi = 16'(base_lo + cdw_pkg::IO_HI_OFS);
    assign sel_lo = (addr_i[15:5] == base_lo[15:5]);
    assign sel_hi = (addr_i[15:5] == base_hi[15:5]);
    assign card_sel_o = sel_lo | sel_hi;
    assign ofs = addr_i[4:0];
    assign host_wr = wr_i & card_sel_o;
    assign dac_wr_any = |dac_wr_ch;

    // Shared 25 us tick; it also serves as the watchdog's internal oscillator.
    always_comb begin
        tick = (pre_cnt_q == cdw_pkg::PRE_W'(TICK_CYCLES - 1));
        pre_cnt_d = tick ? '0 : cdw_pkg::PRE_W'(pre_cnt_q + 1'b1);
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
        end
    end

    // Periodic timer: a reload of N fires every N ticks; zero keeps it silent.
    always_comb begin
        reload_d = reload_q;
        run_d = run_q;
        tcnt_d = tcnt_q;
        tmr_evt = tick && run_q && (reload_q != '0) &&
                  (tcnt_q == cdw_pkg::TMR_W'(reload_q - 1'b1));
        if (tick && run_q) begin
            tcnt_d = tmr_evt ? '0 : cdw_pkg::TMR_W'(tcnt_q + 1'b1);
        end
        if (wr_i && sel_hi && ofs == cdw_pkg::OFS_TMR_LO) begin
            reload_d[15:0] = wdata_i;
        end
        if (wr_i && sel_hi && ofs == cdw_pkg::OFS_TMR_HI) begin
            reload_d[24:16] = wdata_i[8:0];
        end
        // Writing the control register restarts the period from zero.
        if (wr_i && sel_hi && ofs == cdw_pkg::OFS_TMR_CTL) begin
            run_d = wdata_i[0];
            tcnt_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= cdw_pkg::TMR_RELOAD_RST;
            run_q <= 1'b0;
            tcnt_q <= '0;
            tmr_evt_q <= 1'b0;
        end else begin
            reload_q <= reload_d;
            run_q <= run_d;
            tcnt_q <= tcnt_d;
            tmr_evt_q <= tmr_evt;
        end
    end
    assign encoder_latch_o = tmr_evt_q;

    // Watchdog state, counter and fault line.
    always_comb begin
        st_d = st_q;
        wd_cnt_d = wd_cnt_q;
        fault_d = fault_q;
        wd_expire = 1'b0;
        if (host_wr) begin
            fault_d = 1'b0;
        end
        case (st_q)
            cdw_pkg::CDW_WD_RUN: begin
                if (dac_wr_any) begin
                    wd_cnt_d = '0;
                end else if (!wd_en) begin
                    if (tick) begin
                        wd_cnt_d = '0;
                    end
                end else if (tick) begin
                    if (wd_cnt_q == cdw_pkg::WD_W'(WD_TICKS - 1)) begin
                        wd_expire = 1'b1;
                        st_d = cdw_pkg::CDW_WD_BARK;
                        wd_cnt_d = '0;
                        fault_d = 1'b1;
                    end else begin
                        wd_cnt_d = cdw_pkg::WD_W'(wd_cnt_q + 1'b1);
                    end
                end
            end
            cdw_pkg::CDW_WD_BARK: begin
                wd_cnt_d = '0;
                if (dac_wr_any || !wd_en) begin
                    st_d = cdw_pkg::CDW_WD_RUN;
                end
            end
            default: begin
                st_d = cdw_pkg::CDW_WD_RUN;
                wd_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= cdw_pkg::CDW_WD_RUN;
            wd_cnt_q <= '0;
            fault_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wd_cnt_q <= wd_cnt_d;
            fault_q <= fault_d;
        end
    end

    // Without the route jumper the pin is left to the digital port logic.
    assign fault_o = fault_q & route_fitted;
    assign upper_port_bit_seven_o = fault_q & route_fitted;
    assign upper_port_bit_seven_oe_o = route_fitted;

    // Each channel holds a written value and the value on the converter.
    for (genvar i = 0; i < cdw_pkg::DAC_N; i++) begin : g_dac
        logic [cdw_pkg::DAC_W-1:0] pend_d;
        logic [cdw_pkg::DAC_W-1:0] act_d;

        assign dac_wr_ch[i] = wr_i && sel_lo && (ofs == 5'(cdw_pkg::OFS_DAC0 + 2 * i));

        always_comb begin
            pend_d = dac_wr_ch[i] ? wdata_i[cdw_pkg::DAC_W-1:0] : pend_q[i];
            act_d = act_q[i];
            if (wd_expire || (st_q == cdw_pkg::CDW_WD_BARK && !dac_wr_any)) begin
                act_d = '0;
            end else if (!upd_latched && dac_wr_ch[i]) begin
                act_d = wdata_i[cdw_pkg::DAC_W-1:0];
            end else if (upd_latched && tmr_evt) begin
                act_d = pend_d;
            end
        end

        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                pend_q[i] <= cdw_pkg::DAC_RST;
                act_q[i] <= cdw_pkg::DAC_RST;
            end else begin
                pend_q[i] <= pend_d;
                act_q[i] <= act_d;
            end
        end

        assign dac_o[i] = act_q[i];
    end

    // Interrupt status is write-one-to-clear; a new event in the same cycle wins.
    always_comb begin
        logic [1:0] clr;
        clr = '0;
        mask_d = mask_q;
        if (wr_i && sel_hi && ofs == cdw_pkg::OFS_IRQ_STAT) begin
            clr = wdata_i[1:0];
        end
        if (wr_i && sel_hi && ofs == cdw_pkg::OFS_IRQ_MASK) begin
            mask_d = wdata_i[1:0];
        end
        stat_d = stat_q & ~clr;
        stat_d[cdw_pkg::IRQ_TMR_BIT] = stat_d[cdw_pkg::IRQ_TMR_BIT] | tmr_evt;
        stat_d[cdw_pkg::IRQ_WD_BIT] = stat_d[cdw_pkg::IRQ_WD_BIT] | wd_expire;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
            mask_q <= cdw_pkg::IRQ_MASK_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end
    assign irq_o = |(stat_q & mask_q);

    // Read data is valid only in the cycle after the strobe and is zero otherwise.
    always_comb begin
        rdata_d = '0;
        if (rd_i && sel_lo) begin
            if (ofs[4] == 1'b0 && ofs[0] == 1'b0) begin
                rdata_d = {3'h0, pend_q[ofs[3:1]]};
            end else if (ofs == cdw_pkg::OFS_BOARD_TEST_SELECT_REG) begin
                rdata_d = {9'h000, jmp_q};
            end else if (ofs == cdw_pkg::OFS_WDSTAT) begin
                rdata_d = {14'h0000, fault_q, st_q == cdw_pkg::CDW_WD_BARK};
            end
        end else if (rd_i && sel_hi) begin
            case (ofs)
                cdw_pkg::OFS_TMR_LO: rdata_d = reload_q[15:0];
                cdw_pkg::OFS_TMR_HI: rdata_d = {7'h00, reload_q[24:16]};
                cdw_pkg::OFS_TMR_CTL: rdata_d = {15'h0000, run_q};
                cdw_pkg::OFS_IRQ_STAT: rdata_d = {14'h0000, stat_q};
                cdw_pkg::OFS_IRQ_MASK: rdata_d = {14'h0000, mask_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_base_match: assert property (card_sel_o |-> ((addr_i[8:5] ^ jmp_base) == 4'hf))
        else $error("Card selected with an address bit that disagrees with its jumper.");
    a_two_windows: assert property (card_sel_o |-> (addr_i[15:11] == 5'h00 && addr_i[9]))
        else $error("Card selected outside both I/O windows.");
    a_jumper_read: assert property (rd_i && sel_lo && ofs == cdw_pkg::OFS_BOARD_TEST_SELECT_REG
        |=> rdata_o[3:0] == $past(jmp_base))
        else $error("Board test register does not show the base jumpers.");
    a_direct_update: assert property (!upd_latched && dac_wr_ch[0] && st_q == cdw_pkg::CDW_WD_RUN
        |=> dac_o[0] == $past(wdata_i[12:0]))
        else $error("Direct write did not reach the analog output.");
    a_latched_hold: assert property (upd_latched && dac_wr_ch[1] && !tmr_evt
        |=> dac_o[1] == $past(dac_o[1]))
        else $error("Latched mode output changed before the timer expiry.");
    a_encoder_latch: assert property (tmr_evt |=> encoder_latch_o ##1 !encoder_latch_o)
        else $error("Encoder latch pulse missing or stretched after timer expiry.");
    a_timer_irq: assert property (tmr_evt |=> stat_q[cdw_pkg::IRQ_TMR_BIT])
        else $error("Timer expiry did not set its interrupt status.");
    a_wd_restart: assert property (dac_wr_any |=> wd_cnt_q == '0)
        else $error("Analog output write did not restart the watchdog.");
    a_bark_zero: assert property (st_q == cdw_pkg::CDW_WD_BARK |-> dac_o == '0)
        else $error("Analog outputs not zero while the watchdog has expired.");
    a_fault_hold: assert property (fault_o && !host_wr && route_fitted |=> fault_o)
        else $error("Fault line dropped without a board write.");
    a_pin_free: assert property (!route_fitted |-> !upper_port_bit_seven_oe_o && !fault_o)
        else $error("Port bit driven while the route jumper is removed.");
    a_wd_disabled: assert property (!wd_en && $stable(wd_en) && st_q == cdw_pkg::CDW_WD_RUN
        |=> st_q == cdw_pkg::CDW_WD_RUN)
        else $error("Disabled watchdog expired.");
    a_wd_bound: assert property (wd_cnt_q < cdw_pkg::WD_W'(WD_TICKS))
        else $error("Watchdog count ran past its terminal value.");

    c_timer_fires: cover property (tmr_evt ##1 encoder_latch_o);
    c_bark: cover property (wd_expire ##1 st_q == cdw_pkg::CDW_WD_BARK);
    c_fault_routed: cover property (route_fitted && fault_o ##[1:20] !fault_o);
    c_latched_update: cover property (upd_latched && tmr_evt && st_q == cdw_pkg::CDW_WD_RUN);

endmodule

// ==== cdw_pkg.sv ====
package cdw_pkg;

    // Base clock and the shared 25 us tick that drives both timers.
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TICK_US = 25;
    localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

    // Watchdog timeout window, in microseconds, and the terminal count used.
    localparam int unsigned WD_MIN_US = 62500;
    localparam int unsigned WD_TYP_US = 150000;
    localparam int unsigned WD_MAX_US = 250000;
    localparam int unsigned WD_TICKS = WD_TYP_US / TICK_US;

    // Periodic timer reaches ten minutes in 25 us steps.
    localparam int unsigned TMR_MAX_S = 600;
    localparam int unsigned TMR_MAX_TICKS = TMR_MAX_S * 1000000 / TICK_US;

    localparam int unsigned PRE_W = 13;
    localparam int unsigned WD_W = 13;
    localparam int unsigned TMR_W = 25;
    localparam int unsigned DAC_W = 13;
    localparam int unsigned DAC_N = 8;
    localparam int unsigned JMP_W = 7;

    // I/O decode: lower window base before jumpers, and distance to the upper window.
    localparam logic [15:0] IO_BASE = 16'h0200;
    localparam logic [15:0] IO_HI_OFS = 16'h0400;

    // Lower window offsets.
    localparam logic [4:0] OFS_DAC0 = 5'h00;
    localparam logic [4:0] OFS_BOARD_TEST_SELECT_REG = 5'h10;
    localparam logic [4:0] OFS_WDSTAT = 5'h12;
    // Upper window offsets.
    localparam logic [4:0] OFS_TMR_LO = 5'h00;
    localparam logic [4:0] OFS_TMR_HI = 5'h02;
    localparam logic [4:0] OFS_TMR_CTL = 5'h04;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h06;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h08;

    // Interrupt status and mask bit positions.
    localparam int unsigned IRQ_TMR_BIT = 0;
    localparam int unsigned IRQ_WD_BIT = 1;

    // Reset values.
    localparam logic [TMR_W-1:0] TMR_RELOAD_RST = 25'h0000000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [DAC_W-1:0] DAC_RST = 13'h0000;

    typedef enum logic [1:0] {
        CDW_WD_RUN = 2'b01,
        CDW_WD_BARK = 2'b10
    } cdw_wd_state_t;

endpackage

// ==== cdw_host_model.sv ====
`timescale 1ns/1ps

// Host side of the I/O bus. Every transfer is one strobe cycle launched just after an edge.
// It never drives the upper port pin.
module cdw_host_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released lines show the inverse of the last value so a stale bus cannot pass.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    task automatic drive(input logic [15:0] a);
        @(posedge clk_i);
        addr_o <= a;
    endtask
endmodule

// ==== card_decode_dac_update_watchdog_tb_top.sv ====
`timescale 1ns/1ps

module card_decode_dac_update_watchdog_tb_top;
    localparam int unsigned TCK = 4;
    localparam int unsigned WDT = 8;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] jmp = 4'h0;
    logic upd = 1'b0;
    logic route = 1'b0;
    logic wden = 1'b0;
    logic [15:0] addr, wdata, rdata, base, d;
    logic wr, rd, card_sel, enc, irq, fault, pbit, pbit_oe;
    logic [cdw_pkg::DAC_N-1:0][cdw_pkg::DAC_W-1:0] dac;
    int unsigned fail_count = 0;
    int unsigned tests_run = 0;
    int unsigned n;

    cdw_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    cdw_top #(.TICK_CYCLES(TCK), .WD_TICKS(WDT)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .card_sel_o(card_sel), .base_address_jumpers_i(jmp),
        .output_update_select_jumper_i(upd), .fault_output_route_jumper_i(route),
        .watchdog_enable_jumper_i(wden), .dac_o(dac), .encoder_latch_o(enc), .irq_o(irq),
        .fault_o(fault), .upper_port_bit_seven_o(pbit), .upper_port_bit_seven_oe_o(pbit_oe));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bit_chk(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic cyc(input int unsigned k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic rchk(input logic [15:0] ofs, input logic [15:0] exp);
        i_host.rd(base + ofs, d);
        chk(d, exp);
    endtask

    // Jumpers cross two sync stages, so give them a few edges before relying on them.
    task automatic set_jmp(input logic [3:0] j, input logic u, input logic r, input logic e);
        @(posedge clk_i);
        jmp <= j;
        upd <= u;
        route <= r;
        wden <= e;
        cyc(4);
        base = 16'h0200 | {7'h00, ~j, 5'h00};
    endtask

    task automatic wait_latch(output int unsigned k);
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (enc !== 1'b1 && k < 100);
        if (k >= 100) begin
            bit_chk(1'b0, 1'b1);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5000);
        fail_count++;
        complete_run();
    end

    initial begin
        cyc(3);
        resetn_i <= 1'b1;
        cyc(5);
        for (int j = 0; j < 16; j++) begin
            set_jmp(j[3:0], 1'b0, 1'b1, 1'b0);
            i_host.drive(base);
            #1 bit_chk(card_sel, 1'b1);
            i_host.drive(base + 16'h041f);
            #1 bit_chk(card_sel, 1'b1);
            for (int b = 5; b < 9; b++) begin
                i_host.drive(base ^ (16'h0001 << b));
                #1 bit_chk(card_sel, 1'b0);
            end
            rchk(16'h0010, {9'h000, 3'b010, j[3:0]});
        end
        set_jmp(4'h5, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            i_host.wr(base + 16'(2 * i), 16'h0100 + 16'(i) * 16'h0111);
            #1 chk({3'h0, dac[i]}, 16'h0100 + 16'(i) * 16'h0111);
            rchk(16'(2 * i), 16'h0100 + 16'(i) * 16'h0111);
        end
        rchk(16'h0013, 16'h0000);
        rchk(16'h040a, 16'h0000);
        // Keep-alive writes come well inside the timeout, as a live host would.
        repeat (4) begin
            cyc(20);
            i_host.wr(base, 16'h0abc);
        end
        #1 bit_chk(fault, 1'b0);
        chk({3'h0, dac[0]}, 16'h0abc);
        cyc(20);
        #1 bit_chk(fault, 1'b0);
        cyc(20);
        #1 bit_chk(fault, 1'b1);
        bit_chk(pbit, 1'b1);
        bit_chk(pbit_oe, 1'b1);
        for (int i = 0; i < 8; i++) begin
            chk({3'h0, dac[i]}, 16'h0000);
        end
        bit_chk(irq, 1'b0);
        rchk(16'h0012, 16'h0003);
        i_host.wr(base + 16'h0408, 16'h0002);
        #1 bit_chk(fault, 1'b0);
        bit_chk(irq, 1'b1);
        i_host.wr(base + 16'h0406, 16'h0002);
        #1 bit_chk(irq, 1'b0);
        set_jmp(4'h5, 1'b0, 1'b0, 1'b1);
        i_host.wr(base + 16'h0002, 16'h0123);
        cyc(40);
        #1 bit_chk(fault, 1'b0);
        bit_chk(pbit_oe, 1'b0);
        bit_chk(pbit, 1'b0);
        chk({3'h0, dac[1]}, 16'h0000);
        set_jmp(4'h5, 1'b0, 1'b0, 1'b0);
        i_host.wr(base + 16'h0004, 16'h0155);
        cyc(60);
        #1 chk({3'h0, dac[2]}, 16'h0155);
        set_jmp(4'h5, 1'b1, 1'b0, 1'b0);
        i_host.wr(base + 16'h0400, 16'h0003);
        i_host.wr(base + 16'h0402, 16'h0000);
        i_host.wr(base + 16'h0404, 16'h0001);
        wait_latch(n);
        wait_latch(n);
        chk(16'(n), 16'(3 * TCK));
        i_host.wr(base + 16'h0004, 16'h0777);
        #1 chk({3'h0, dac[2]}, 16'h0155);
        wait_latch(n);
        chk({3'h0, dac[2]}, 16'h0777);
        i_host.rd(base + 16'h0406, d);
        chk(d & 16'h0001, 16'h0001);
        complete_run();
    end
endmodule
